// ==== core/dpsc_defs.vh ====
// constants of the dual pot serial control block
`ifndef DPSC_DEFS_VH
`define DPSC_DEFS_VH
`define DPSC_WORD_BITS   5'd24
`define DPSC_CMD_MSB     23
`define DPSC_CMD_LSB     20
`define DPSC_SLOT_MSB    19
`define DPSC_SLOT_LSB    18
`define DPSC_CHAN_MSB    17
`define DPSC_CHAN_LSB    16
`define DPSC_MODE_BIT    8
`define DPSC_TAP_MSB     7
`define DPSC_CMD_NOP     4'h0
`define DPSC_CMD_RD_TAP  4'hc
`define DPSC_CMD_WR_TAP  4'h4
`define DPSC_CMD_RD_NV   4'ha
`define DPSC_CMD_PRG_NV  4'h2
`define DPSC_CMD_LD_TAP  4'h1
`define DPSC_CMD_SV_TAP  4'h3
`define DPSC_NV_RESET    9'h080
`define DPSC_BUSY_CYC    8'd64
`endif

// ==== core/dpsc_slot_mem.v ====
// nonvolatile slot store, eight 9-bit words with registered read
`timescale 1ns/1ps
module dpsc_slot_mem (
	input  wire       clk,
	input  wire       resetn,
	input  wire       wr_en,
	input  wire [2:0] wr_addr,
	input  wire [8:0] wr_data,
	input  wire [2:0] rd_addr,
	output reg  [8:0] rd_data
);
`include "dpsc_defs.vh"
	reg [8:0] mem [0:7];
	integer   i;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 8; i = i + 1)
				mem[i] <= `DPSC_NV_RESET;
			rd_data <= `DPSC_NV_RESET;
		end else begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			rd_data <= mem[rd_addr];
		end
	end
endmodule // dpsc_slot_mem

// ==== core/dpsc_top.v ====
// serial control of a dual 256-tap nonvolatile potentiometer
// Behaviour
// - sample input bits on serial clock rise
// - chip select high releases data output
// - select low active; busy cycle finishes
// - ignore everything until first select fall
// - data output open drain, shifts read data
// - first bit at select fall, then clock fall
// - data output passes stream down chain
// - open-drain ready low flags slow commands
// - write protect low blocks all stores
// - four 9-bit nonvolatile slots per channel
// - power-up copies slot 0 to tap
// - tap register holds 8-bit position
// - buffer mode bit: 0 off, 1 on
// - buffer mode kept per channel
// - buffer mode set via program then load
// - direct tap write keeps buffer mode
// - tap set by write or slot load
// - 24-bit command word, msb first
// - channel code 00 or 01, others ignored
// - select rise ends and executes command
// - previous 24 bits shift out during next
`timescale 1ns/1ps
module dpsc_top (
	input  wire       clk,
	input  wire       resetn,
	input  wire       sclk,
	input  wire       cs_n,
	input  wire       sdi,
	input  wire       wp_n,
	output reg        sdo_out,
	output reg        sdo_oe,
	output reg        ready_n_out,
	output reg        ready_n_oe,
	output reg  [7:0] wiper_out_first,
	output reg  [7:0] wiper_out_second,
	output reg        buf_on_first,
	output reg        buf_on_second
);
`include "dpsc_defs.vh"
	localparam ST_BOOT0 = 3'd0;
	localparam ST_BOOT1 = 3'd1;
	localparam ST_BOOT2 = 3'd2;
	localparam ST_IDLE  = 3'd3;
	localparam ST_EXEC  = 3'd4;
	localparam ST_BUSY  = 3'd5;
	localparam ST_BOOT3 = 3'd6;

	// pins cross from the master's domain
	reg  [1:0] sclk_s;
	reg  [1:0] cs_s;
	reg  [1:0] sdi_s;
	reg  [1:0] wp_s;
	reg        sclk_d;
	reg        cs_d;
	reg        armed;
	reg  [23:0] shreg;
	reg  [23:0] cmd;
	reg  [2:0] state;
	reg  [7:0] busy_cnt;
	reg  [7:0] tap0;
	reg  [7:0] tap1;
	reg        mode0;
	reg        mode1;
	reg        slow;
	reg        pend_rd;
	reg  [8:0] rd_word;
	reg        mem_we;
	reg  [2:0] mem_waddr;
	reg  [8:0] mem_wdata;
	reg  [2:0] mem_raddr;
	wire [8:0] mem_rdata;
	wire       sclk_rise = sclk_s[1] & ~sclk_d;
	wire       sclk_fall = ~sclk_s[1] & sclk_d;
	wire       cs_fall   = ~cs_s[1] & cs_d;
	wire       cs_rise   = cs_s[1] & ~cs_d;
	wire [3:0] op        = cmd[`DPSC_CMD_MSB:`DPSC_CMD_LSB];
	wire [1:0] slot      = cmd[`DPSC_SLOT_MSB:`DPSC_SLOT_LSB];
	wire [1:0] chan      = cmd[`DPSC_CHAN_MSB:`DPSC_CHAN_LSB];
	wire       chan_ok   = ~chan[1];
	wire [7:0] cur_tap   = chan[0] ? tap1 : tap0;
	wire       cur_mode  = chan[0] ? mode1 : mode0;

	dpsc_slot_mem u_mem (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_s <= 2'b00;
			cs_s   <= 2'b11;
			sdi_s  <= 2'b00;
			wp_s   <= 2'b11;
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_s <= {sclk_s[0], sclk};
			cs_s   <= {cs_s[0], cs_n};
			sdi_s  <= {sdi_s[0], sdi};
			wp_s   <= {wp_s[0], wp_n};
			sclk_d <= sclk_s[1];
			cs_d   <= cs_s[1];
		end
	end

	// serial shifter; stream passes down the chain
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed   <= 1'b0;
			shreg   <= 24'h00_0000;
			sdo_out <= 1'b1;
			sdo_oe  <= 1'b0;
		end else begin
			if (cs_fall)
				armed <= 1'b1;
			if (cs_s[1]) begin
				sdo_oe  <= 1'b0;
				sdo_out <= 1'b1;
			end else if (cs_fall) begin
				// open drain: drive only a low
				sdo_oe  <= ~shreg[23];
				sdo_out <= 1'b0;
			end else if (sclk_fall) begin
				sdo_oe  <= ~shreg[23];
				sdo_out <= 1'b0;
			end
			if (pend_rd && state == ST_IDLE && cs_s[1])
				shreg <= {shreg[23:9], rd_word};
			else if (!cs_s[1] && sclk_rise && (armed || cs_fall))
				shreg <= {shreg[22:0], sdi_s[1]};
		end
	end

	// command engine
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state       <= ST_BOOT0;
			cmd         <= 24'h00_0000;
			busy_cnt    <= 8'h00;
			tap0        <= 8'h00;
			tap1        <= 8'h00;
			mode0       <= 1'b0;
			mode1       <= 1'b0;
			slow        <= 1'b0;
			pend_rd     <= 1'b0;
			rd_word     <= 9'h000;
			mem_we      <= 1'b0;
			mem_waddr   <= 3'd0;
			mem_wdata   <= 9'h000;
			mem_raddr   <= 3'd0;
			ready_n_out <= 1'b0;
			ready_n_oe  <= 1'b1;
			wiper_out_first  <= 8'h00;
			wiper_out_second <= 8'h00;
			buf_on_first     <= 1'b0;
			buf_on_second    <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			wiper_out_first  <= tap0;
			wiper_out_second <= tap1;
			buf_on_first     <= mode0;
			buf_on_second    <= mode1;
			case (state)
			ST_BOOT0: begin
				mem_raddr <= 3'd0;
				state     <= ST_BOOT1;
			end
			ST_BOOT1: begin
				mem_raddr <= 3'd4;
				tap0      <= mem_rdata[`DPSC_TAP_MSB:0];
				mode0     <= mem_rdata[`DPSC_MODE_BIT];
				state     <= ST_BOOT2;
			end
			// registered read: slot 4 data shows two edges after its address
			ST_BOOT2: begin
				state <= ST_BOOT3;
			end
			ST_BOOT3: begin
				tap1       <= mem_rdata[`DPSC_TAP_MSB:0];
				mode1      <= mem_rdata[`DPSC_MODE_BIT];
				ready_n_oe <= 1'b0;
				state      <= ST_IDLE;
			end
			ST_IDLE: begin
				if (pend_rd && cs_s[1])
					pend_rd <= 1'b0;
				if (cs_rise && armed) begin
					cmd   <= shreg;
					state <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				// slot index = channel:slot for per channel storage
				mem_raddr <= {chan[0], slot};
				slow      <= 1'b0;
				busy_cnt  <= `DPSC_BUSY_CYC;
				state     <= ST_IDLE;
				if (chan_ok) begin
					case (op)
					`DPSC_CMD_WR_TAP: begin
						// mode bit ignored on direct write
						if (wp_s[1]) begin
							if (chan[0])
								tap1 <= cmd[`DPSC_TAP_MSB:0];
							else
								tap0 <= cmd[`DPSC_TAP_MSB:0];
						end
					end
					`DPSC_CMD_RD_TAP: begin
						rd_word <= {cur_mode, cur_tap};
						pend_rd <= 1'b1;
						state   <= ST_BUSY;
					end
					`DPSC_CMD_RD_NV, `DPSC_CMD_LD_TAP: begin
						slow  <= 1'b1;
						state <= ST_BUSY;
					end
					`DPSC_CMD_PRG_NV: begin
						mem_we    <= wp_s[1];
						mem_waddr <= {chan[0], slot};
						mem_wdata <= cmd[`DPSC_MODE_BIT:0];
						state     <= ST_BUSY;
					end
					`DPSC_CMD_SV_TAP: begin
						mem_we    <= wp_s[1];
						mem_waddr <= {chan[0], slot};
						mem_wdata <= {cur_mode, cur_tap};
						state     <= ST_BUSY;
					end
					default: state <= ST_IDLE;
					endcase
				end
				if (chan_ok && (op == `DPSC_CMD_RD_TAP || op == `DPSC_CMD_RD_NV ||
				    op == `DPSC_CMD_PRG_NV || op == `DPSC_CMD_LD_TAP ||
				    op == `DPSC_CMD_SV_TAP)) begin
					ready_n_oe  <= 1'b1;
					ready_n_out <= 1'b0;
				end
			end
			ST_BUSY: begin
				// internal cycle runs on regardless of select
				busy_cnt <= busy_cnt - 8'd1;
				if (busy_cnt == `DPSC_BUSY_CYC - 8'd2 && slow) begin
					if (op == `DPSC_CMD_RD_NV) begin
						rd_word <= mem_rdata;
						pend_rd <= 1'b1;
					end else if (wp_s[1]) begin
						// load copies mode bit too
						if (chan[0]) begin
							tap1  <= mem_rdata[`DPSC_TAP_MSB:0];
							mode1 <= mem_rdata[`DPSC_MODE_BIT];
						end else begin
							tap0  <= mem_rdata[`DPSC_TAP_MSB:0];
							mode0 <= mem_rdata[`DPSC_MODE_BIT];
						end
					end
				end
				if (busy_cnt == 8'd1) begin
					ready_n_oe <= 1'b0;
					state      <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // dpsc_top

// ==== sim/dpsc_chk.sv ====
// port assertions for the serial control block
`timescale 1ns/1ps
module dpsc_chk (
	input wire       clk,
	input wire       resetn,
	input wire       cs_n,
	input wire       wp_n,
	input wire       sdo_out,
	input wire       sdo_oe,
	input wire       ready_n_out,
	input wire       ready_n_oe,
	input wire [7:0] wiper_out_first,
	input wire [7:0] wiper_out_second,
	input wire       buf_on_first,
	input wire       buf_on_second
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// 8 cycles covers the input sync and output register
	a_sdo_hiz: assert property (cs_n [*8] |-> !sdo_oe)
		else $error("sdo driven while idle");
	a_sdo_drain: assert property (sdo_oe |-> !sdo_out)
		else $error("sdo driven high");
	a_rdy_drain: assert property (ready_n_oe |-> !ready_n_out)
		else $error("ready driven high");
	a_busy_min: assert property ($rose(ready_n_oe) |-> ready_n_oe [*8])
		else $error("busy too short");
	a_busy_end: assert property (ready_n_oe |-> ##[1:90] !ready_n_oe)
		else $error("busy never ends");
	a_wp_tap: assert property ((!wp_n) [*8] |=>
		$stable({wiper_out_first, wiper_out_second}))
		else $error("tap changed under protect");
	a_wp_mode: assert property ((!wp_n) [*8] |=>
		$stable({buf_on_first, buf_on_second}))
		else $error("mode changed under protect");
	a_frame_tap: assert property ((!cs_n) [*8] |=>
		$stable({wiper_out_first, wiper_out_second, buf_on_first}))
		else $error("tap changed inside frame");
	cover property ($rose(ready_n_oe));
	cover property ($rose(buf_on_first));
	cover property (sdo_oe && !cs_n);
endmodule // dpsc_chk

// ==== sim/dpsc_master.sv ====
// serial master model driving the control port
`timescale 1ns/1ps
module dpsc_master (
	input  wire clk,
	input  wire sdo_line,
	input  wire rdy_line,
	output reg  sclk,
	output reg  cs_n,
	output reg  sdi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b1;
	end
	task automatic hold(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// bounded so a stuck busy cannot hang us
	task automatic idle;
		integer i;
		begin
			for (i = 0; i < 400 && !rdy_line; i = i + 1)
				hold(1);
			hold(2);
		end
	endtask
	// 10 clk half period gives the 160 ns link clock
	task automatic xfer(input [23:0] w, output [23:0] r);
		integer i;
		begin
			cs_n <= 1'b0;
			for (i = 23; i >= 0; i = i - 1) begin
				sdi <= w[i];
				hold(10);
				sclk <= 1'b1;
				hold(1);
				r[i] = sdo_line;
				hold(9);
				sclk <= 1'b0;
			end
			hold(10);
			cs_n <= 1'b1;
			sdi <= ~sdi;
			hold(12);
			idle;
		end
	endtask
endmodule // dpsc_master

// ==== sim/dpsc_top_tb_top.sv ====
// bench for the dual pot serial control block
`timescale 1ns/1ps
module dpsc_top_tb_top;
	reg         clk;
	reg         resetn;
	reg         wp_n;
	wire        sclk, cs_n, sdi;
	wire        sdo_out, sdo_oe, ready_n_out, ready_n_oe;
	wire  [7:0] w0, w1;
	wire        b0, b1;
	integer     err_count;
	integer     n_compared;
	integer     cyc;
	reg  [23:0] r;
	// pull-ups on both open-drain lines
	wire        sdo_line = sdo_oe ? sdo_out : 1'b1;
	wire        rdy_line = ready_n_oe ? ready_n_out : 1'b1;
	wire [23:0] st = {6'h00, b1, b0, w1, w0};
	dpsc_top dpsc_top_i (.clk(clk), .resetn(resetn), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .wp_n(wp_n), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .ready_n_out(ready_n_out), .ready_n_oe(ready_n_oe),
		.wiper_out_first(w0), .wiper_out_second(w1),
		.buf_on_first(b0), .buf_on_second(b1));
	dpsc_master dpsc_master_i (.clk(clk), .sdo_line(sdo_line),
		.rdy_line(rdy_line), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
	always #4 clk = ~clk;
	task send(input [3:0] c, input [1:0] s, input [1:0] ch, input [8:0] d);
		dpsc_master_i.xfer({c, s, ch, 7'h00, d}, r);
	endtask
	task chk(input [23:0] seen, input [23:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("FAIL %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task results;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count = err_count + 1;
			results;
		end
	end
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		wp_n = 1'b1;
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		dpsc_master_i.idle;
		chk(st, 24'h00_8080);
		send(4'h4, 2'd0, 2'd0, 9'h135);
		send(4'h4, 2'd0, 2'd1, 9'h0ca);
		send(4'h4, 2'd0, 2'd2, 9'h011);
		chk(st, 24'h00_ca35);
		send(4'h0, 2'd0, 2'd0, 9'h000);
		chk(r, {4'h4, 4'h2, 7'h00, 9'h011});
		send(4'h2, 2'd2, 2'd0, 9'h1a5);
		send(4'h1, 2'd2, 2'd0, 9'h000);
		chk(st, 24'h01_caa5);
		send(4'ha, 2'd2, 2'd0, 9'h000);
		send(4'h0, 2'd0, 2'd0, 9'h000);
		chk(r & 24'h1ff, 24'h1a5);
		// save ch1, clobber it, then restore it
		send(4'h3, 2'd3, 2'd1, 9'h000);
		send(4'h4, 2'd0, 2'd1, 9'h000);
		send(4'h1, 2'd3, 2'd1, 9'h000);
		chk(st, 24'h01_caa5);
		send(4'hc, 2'd0, 2'd0, 9'h000);
		send(4'h0, 2'd0, 2'd0, 9'h000);
		chk(r & 24'h1ff, 24'h1a5);
		wp_n <= 1'b0;
		send(4'h4, 2'd0, 2'd0, 9'h011);
		send(4'h2, 2'd2, 2'd0, 9'h000);
		send(4'ha, 2'd2, 2'd0, 9'h000);
		send(4'h0, 2'd0, 2'd0, 9'h000);
		chk(r & 24'h1ff, 24'h1a5);
		chk(st, 24'h01_caa5);
		results;
	end
endmodule // dpsc_top_tb_top
bind dpsc_top dpsc_chk dpsc_chk_i (.clk(clk), .resetn(resetn), .cs_n(cs_n),
	.wp_n(wp_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
	.ready_n_out(ready_n_out), .ready_n_oe(ready_n_oe),
	.wiper_out_first(wiper_out_first), .wiper_out_second(wiper_out_second),
	.buf_on_first(buf_on_first), .buf_on_second(buf_on_second));
